// file: rtl/energy_manager_config_status_regs.sv
`timescale 1ns/1ns
// Functional notes
// - Balance/limit bit 4 picks max storage voltage: 0 is 4.95 V, 1 is 5.54 V.
// - Threshold bits 2:0 pick battery minimum 2.4 to 3.2 V, default 000.
// - Bits 7:5 pick charge current 2/4/8/16 mA or 50 mA emergency, default 010.
// - Warning bits 3:0 pick early-warning level 2.4 to 4.3 V, default 0000.
// - Warning bit 4 enables the early-warning comparator.
// - Threshold bit 4 set floats high-side output in standby and active.
// - Profile index is reg 7 bits 1:0 over reg 8 bits 7:4; zero is fixed.
// - Margin bits 1:0 target 2.19, 2.6 or 2.95 V; default 11.
// - Energy count reads MSB at register 1 through LSB at register 4.
// - Energy count clears when the next charge cycle begins.
// - Actual voltage code updates only in charge and active states.
// - Target end-of-charge code loads when the charge state begins.
// - Both voltage codes share one five-bit monotonic scale up to 5.54 V.
module energy_manager_config_status_regs #(
  parameter int CNT_W = 32
) (
  // Clock, reset, enable
  input  wire logic                               sys_clk,
  input  wire logic                               rst_n,
  input  wire logic                               ce,
  // Byte register port from the serial front end
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  input  wire logic [7:0]                         reg_addr,
  input  wire logic [emgr_pkg::BYTE_W-1:0]        reg_wdata,
  output logic      [emgr_pkg::BYTE_W-1:0]        reg_rdata,
  output logic                                    reg_rvalid,
  // Device state and measurement
  input  wire logic                               charge_state,
  input  wire logic                               active_state,
  input  wire logic                               standby_state,
  input  wire logic                               charge_start,
  input  wire logic                               energy_tick,
  input  wire logic [emgr_pkg::VCODE_W-1:0]       vcap_code_pin,
  input  wire logic [emgr_pkg::VCODE_W-1:0]       chend_code,
  // Configuration to the analog side
  output logic                                    vcap_max_high,
  output logic      [emgr_pkg::VCODE_W-1:0]       vcap_max_code,
  output logic      [emgr_pkg::VMIN_W-1:0]        vmin_code,
  output logic      [emgr_pkg::ICH_W-1:0]         ich_code,
  output logic      [emgr_pkg::VEW_W-1:0]         vew_code,
  output logic                                    ew_enable,
  output logic                                    high_side_hiz,
  output logic      [emgr_pkg::PROFILE_W-1:0]     profile_index,
  output logic                                    fixed_mode,
  output logic      [emgr_pkg::MARGIN_W-1:0]      opt_margin,
  output logic      [emgr_pkg::VCODE_W-1:0]       margin_target_code,
  output logic                                    cfg_misuse
);

  // Address match for one register; the enable and write or read gating come from wr_go or rd_go
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic                            wr_go;
  logic                            rd_go;
  logic                            vcap_max_q;
  logic [emgr_pkg::VMIN_W-1:0]     vmin_q;
  logic [emgr_pkg::ICH_W-1:0]      ich_q;
  logic                            hiz_q;
  logic [emgr_pkg::VEW_W-1:0]      vew_q;
  logic                            ew_en_q;
  logic [emgr_pkg::OPT_UP_W-1:0]   opt_up_q;
  logic [emgr_pkg::OPT_LO_W-1:0]   opt_lo_q;
  logic [emgr_pkg::MARGIN_W-1:0]   margin_q;
  logic [emgr_pkg::VCODE_W-1:0]    vcap_meta_q;
  logic [emgr_pkg::VCODE_W-1:0]    vcap_sync_q;
  logic [emgr_pkg::VCODE_W-1:0]    vcap_prev_q;
  logic [emgr_pkg::VCODE_W-1:0]    vcap_act_q;
  logic [emgr_pkg::VCODE_W-1:0]    vcap_tgt_q;
  logic [CNT_W-1:0]                snap_q;
  logic [emgr_pkg::BYTE_W-1:0]     rdata_q;
  logic                            rvalid_q;
  logic                            misuse_q;
  logic [emgr_pkg::BYTE_W-1:0]     rdata_d;

  gauge_if #(.CNT_W(CNT_W)) gif ();

  assign wr_go = ce && reg_wr;
  assign rd_go = ce && reg_rd;

  energy_gauge #(.CNT_W(CNT_W)) u_gauge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .gif     (gif.gauge)
  );

  assign gif.clear = charge_start;
  assign gif.tick  = energy_tick;

  // Threshold/current register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vmin_q <= emgr_pkg::VMIN_RST;
      ich_q  <= emgr_pkg::ICH_RST;
      hiz_q  <= 1'b0;
    end else if (wr_go && hit(reg_addr, emgr_pkg::ADDR_THR_CUR)) begin
      vmin_q <= reg_wdata[emgr_pkg::VMIN_LSB +: emgr_pkg::VMIN_W];
      ich_q  <= reg_wdata[emgr_pkg::ICH_LSB +: emgr_pkg::ICH_W];
      hiz_q  <= reg_wdata[emgr_pkg::HIZ_BIT];
    end
  end

  // Warning register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vew_q   <= emgr_pkg::VEW_RST;
      ew_en_q <= 1'b0;
    end else if (wr_go && hit(reg_addr, emgr_pkg::ADDR_WARN)) begin
      vew_q   <= reg_wdata[emgr_pkg::VEW_LSB +: emgr_pkg::VEW_W];
      ew_en_q <= reg_wdata[emgr_pkg::EW_EN_BIT];
    end
  end

  // Balance/limit register; balance fields live elsewhere
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcap_max_q <= 1'b0;
    end else if (wr_go && hit(reg_addr, emgr_pkg::ADDR_BAL_LIM)) begin
      vcap_max_q <= reg_wdata[emgr_pkg::VCAPMAX_BIT];
    end
  end

  // Profile index halves; mode bits of the command byte are not kept here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_up_q <= emgr_pkg::OPT_UP_RST;
      opt_lo_q <= emgr_pkg::OPT_LO_RST;
    end else if (wr_go) begin
      if (hit(reg_addr, emgr_pkg::ADDR_OPT_UPPER)) begin
        opt_up_q <= reg_wdata[emgr_pkg::OPT_UP_LSB +: emgr_pkg::OPT_UP_W];
      end
      if (hit(reg_addr, emgr_pkg::ADDR_MODE_CMD)) begin
        opt_lo_q <= reg_wdata[emgr_pkg::OPT_LO_LSB +: emgr_pkg::OPT_LO_W];
      end
    end
  end

  // Margin register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      margin_q <= emgr_pkg::MARGIN_RST;
    end else if (wr_go && hit(reg_addr, emgr_pkg::ADDR_MARGIN)) begin
      margin_q <= reg_wdata[emgr_pkg::MARGIN_LSB +: emgr_pkg::MARGIN_W];
    end
  end

  // Sticky flag for current and margin codes the host must not use; diagnostic only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      misuse_q <= 1'b0;
    end else if (ce && ((ich_q > emgr_pkg::ICH_MAX) ||
                        (margin_q == emgr_pkg::MARGIN_MIN))) begin
      misuse_q <= 1'b1;
    end
  end

  // Converter code comes from the analog domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcap_meta_q <= emgr_pkg::VCODE_RST;
      vcap_sync_q <= emgr_pkg::VCODE_RST;
    end else if (ce) begin
      vcap_meta_q <= vcap_code_pin;
      vcap_sync_q <= vcap_meta_q;
    end
  end

  // Multi-bit code may be caught mid-change; take it only once two samples agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcap_prev_q <= emgr_pkg::VCODE_RST;
    end else if (ce) begin
      vcap_prev_q <= vcap_sync_q;
    end
  end

  // Leakage decay in standby must not show, so hold outside charge/active
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcap_act_q <= emgr_pkg::VCODE_RST;
    end else if (ce && (charge_state || active_state) && (vcap_sync_q == vcap_prev_q)) begin
      vcap_act_q <= vcap_sync_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcap_tgt_q <= emgr_pkg::VCODE_RST;
    end else if (ce && charge_start) begin
      vcap_tgt_q <= chend_code;
    end
  end

  // Snapshot on the MSB read keeps the four bytes coherent
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= '0;
    end else if (rd_go && hit(reg_addr, emgr_pkg::ADDR_ENERGY3)) begin
      snap_q <= gif.count;
    end else if (ce && charge_start) begin
      snap_q <= '0;
    end
  end

  always_comb begin
    rdata_d = emgr_pkg::BYTE_ZERO;
    unique case (reg_addr)
      emgr_pkg::ADDR_ENERGY3:  rdata_d = gif.count[31:24];
      emgr_pkg::ADDR_ENERGY2:  rdata_d = snap_q[23:16];
      emgr_pkg::ADDR_ENERGY1:  rdata_d = snap_q[15:8];
      emgr_pkg::ADDR_ENERGY0:  rdata_d = snap_q[7:0];
      emgr_pkg::ADDR_VCAP_ACT: rdata_d = {3'h0, vcap_act_q};
      emgr_pkg::ADDR_VCAP_TGT: rdata_d = {3'h0, vcap_tgt_q};
      default:                 rdata_d = emgr_pkg::BYTE_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= emgr_pkg::BYTE_ZERO;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata     = rdata_q;
  assign reg_rvalid    = rvalid_q;
  assign vcap_max_high = vcap_max_q;
  assign vcap_max_code = vcap_max_q ? emgr_pkg::VC_5V54 : emgr_pkg::VC_4V95;
  assign vmin_code     = vmin_q;
  assign ich_code      = ich_q;
  assign vew_code      = vew_q;
  assign ew_enable     = ew_en_q;
  assign high_side_hiz = hiz_q && (standby_state || active_state);
  assign profile_index = {opt_up_q, opt_lo_q};
  assign fixed_mode    = (profile_index == emgr_pkg::PROFILE_FIXED);
  assign opt_margin    = margin_q;
  assign cfg_misuse    = misuse_q;

  always_comb begin
    margin_target_code = emgr_pkg::VC_2V95;
    unique case (margin_q)
      emgr_pkg::MARGIN_NOM:   margin_target_code = emgr_pkg::VC_2V19;
      emgr_pkg::MARGIN_SAFE:  margin_target_code = emgr_pkg::VC_2V60;
      emgr_pkg::MARGIN_EXTRA: margin_target_code = emgr_pkg::VC_2V95;
      emgr_pkg::MARGIN_MIN:   margin_target_code = emgr_pkg::VC_BELOW;
    endcase
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_VCAPMAX_WRITE: assert property (
    wr_go && reg_addr == emgr_pkg::ADDR_BAL_LIM |=>
      vcap_max_code == ($past(reg_wdata[4]) ? emgr_pkg::VC_5V54 : emgr_pkg::VC_4V95))
    else $error("max storage voltage code wrong after write");

  AST_VMIN_WRITE: assert property (
    wr_go && reg_addr == emgr_pkg::ADDR_THR_CUR |=> vmin_code == $past(reg_wdata[2:0]))
    else $error("battery minimum code not stored");

  AST_ICH_WRITE: assert property (
    wr_go && reg_addr == emgr_pkg::ADDR_THR_CUR |=> ich_code == $past(reg_wdata[7:5]))
    else $error("charge current code not stored");

  AST_WARN_WRITE: assert property (
    wr_go && reg_addr == emgr_pkg::ADDR_WARN |=>
      vew_code == $past(reg_wdata[3:0]) && ew_enable == $past(reg_wdata[4]))
    else $error("warning register not stored");

  AST_HIZ_STATES: assert property (
    wr_go && reg_addr == emgr_pkg::ADDR_THR_CUR |=>
      high_side_hiz == ($past(reg_wdata[4]) && (standby_state || active_state)))
    else $error("high side float setting not applied");

  AST_PROFILE_UPPER: assert property (
    wr_go && reg_addr == emgr_pkg::ADDR_OPT_UPPER |=>
      profile_index[5:4] == $past(reg_wdata[1:0]))
    else $error("profile upper bits not taken");

  AST_MARGIN_TARGET: assert property (
    wr_go && reg_addr == emgr_pkg::ADDR_MARGIN && reg_wdata[1:0] == 2'h1 |=>
      margin_target_code == emgr_pkg::VC_2V19)
    else $error("nominal margin target wrong");

  AST_MSB_READ: assert property (
    rd_go && reg_addr == emgr_pkg::ADDR_ENERGY3 && !charge_start |=>
      reg_rvalid && reg_rdata == $past(gif.count[31:24]) ##0
      (snap_q == $past(gif.count)))
    else $error("energy MSB read mismatch");

  AST_COUNT_CLEAR: assert property (
    ce && charge_start |=> gif.count == '0)
    else $error("energy count not cleared at charge start");

  AST_VCAP_HOLD: assert property (
    ce && !charge_state && !active_state |=> $stable(vcap_act_q))
    else $error("actual voltage code moved outside charge or active");

  AST_TARGET_LOAD: assert property (
    ce && charge_start |=> vcap_tgt_q == $past(chend_code))
    else $error("target code not loaded at charge start");

  COV_CHARGE_START: cover property (ce && charge_start ##1 ce && energy_tick);
  COV_FULL_READ: cover property (rd_go && reg_addr == emgr_pkg::ADDR_ENERGY3 ##1
    rd_go && reg_addr == emgr_pkg::ADDR_ENERGY0);
  COV_HIZ: cover property (high_side_hiz && standby_state);
  COV_FIXED_LEAVE: cover property (fixed_mode ##1 !fixed_mode);

endmodule : energy_manager_config_status_regs

// file: rtl/emgr_pkg.sv
package emgr_pkg;

  // Register offsets on the serial configuration port
  localparam logic [7:0] ADDR_ENERGY3   = 8'h01;
  localparam logic [7:0] ADDR_ENERGY2   = 8'h02;
  localparam logic [7:0] ADDR_ENERGY1   = 8'h03;
  localparam logic [7:0] ADDR_ENERGY0   = 8'h04;
  localparam logic [7:0] ADDR_VCAP_ACT  = 8'h05;
  localparam logic [7:0] ADDR_VCAP_TGT  = 8'h06;
  localparam logic [7:0] ADDR_OPT_UPPER = 8'h07;
  localparam logic [7:0] ADDR_MODE_CMD  = 8'h08;
  localparam logic [7:0] ADDR_THR_CUR   = 8'h0a;
  localparam logic [7:0] ADDR_WARN      = 8'h0b;
  localparam logic [7:0] ADDR_BAL_LIM   = 8'h0c;
  localparam logic [7:0] ADDR_MARGIN    = 8'h0d;

  // Field positions
  localparam int VCAPMAX_BIT   = 4;
  localparam int VMIN_LSB      = 0;
  localparam int VMIN_W        = 3;
  localparam int HIZ_BIT       = 4;
  localparam int ICH_LSB       = 5;
  localparam int ICH_W         = 3;
  localparam int VEW_LSB       = 0;
  localparam int VEW_W         = 4;
  localparam int EW_EN_BIT     = 4;
  localparam int OPT_UP_LSB    = 0;
  localparam int OPT_UP_W      = 2;
  localparam int OPT_LO_LSB    = 4;
  localparam int OPT_LO_W      = 4;
  localparam int MARGIN_LSB    = 0;
  localparam int MARGIN_W      = 2;
  localparam int VCODE_W       = 5;
  localparam int BYTE_W        = 8;
  localparam int PROFILE_W     = 6;

  // Reset values
  localparam logic [VMIN_W-1:0]   VMIN_RST    = 3'h0;
  localparam logic [ICH_W-1:0]    ICH_RST     = 3'h2;
  localparam logic [VEW_W-1:0]    VEW_RST     = 4'h0;
  localparam logic [OPT_UP_W-1:0] OPT_UP_RST  = 2'h0;
  localparam logic [OPT_LO_W-1:0] OPT_LO_RST  = 4'h0;
  localparam logic [MARGIN_W-1:0] MARGIN_RST  = 2'h3;
  localparam logic [VCODE_W-1:0]  VCODE_RST   = 5'h00;
  localparam logic [PROFILE_W-1:0] PROFILE_FIXED = 6'h00;

  // Largest legal codes
  localparam logic [ICH_W-1:0]    ICH_MAX     = 3'h4;
  localparam logic [VMIN_W-1:0]   VMIN_MAX    = 3'h4;
  localparam logic [VEW_W-1:0]    VEW_MAX     = 4'h9;

  // Voltage scale codes (shared five-bit storage voltage scale)
  localparam logic [VCODE_W-1:0]  VC_2V19     = 5'h0c;
  localparam logic [VCODE_W-1:0]  VC_2V60     = 5'h0e;
  localparam logic [VCODE_W-1:0]  VC_2V95     = 5'h10;
  localparam logic [VCODE_W-1:0]  VC_4V95     = 5'h1c;
  localparam logic [VCODE_W-1:0]  VC_5V54     = 5'h1f;
  localparam logic [VCODE_W-1:0]  VC_BELOW    = 5'h02;

  // Optimization margin codes
  localparam logic [MARGIN_W-1:0] MARGIN_MIN   = 2'h0;
  localparam logic [MARGIN_W-1:0] MARGIN_NOM   = 2'h1;
  localparam logic [MARGIN_W-1:0] MARGIN_SAFE  = 2'h2;
  localparam logic [MARGIN_W-1:0] MARGIN_EXTRA = 2'h3;

  localparam logic [BYTE_W-1:0]   BYTE_ZERO   = 8'h00;

endpackage : emgr_pkg

// file: rtl/gauge_if.sv
`timescale 1ns/1ns
interface gauge_if #(
  parameter int CNT_W = 32
);
  logic             clear;
  logic             tick;
  logic [CNT_W-1:0] count;

  modport ctrl  (output clear, output tick, input count);
  modport gauge (input clear, input tick, output count);
endinterface : gauge_if

// file: rtl/energy_gauge.sv
`timescale 1ns/1ns
module energy_gauge #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Counter link
  gauge_if.gauge   gif
);

  logic [CNT_W-1:0] count_q;

  // Clear beats a tick: a new cycle starts from nothing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (ce) begin
      if (gif.clear) begin
        count_q <= '0;
      end else if (gif.tick) begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign gif.count = count_q;

endmodule : energy_gauge

// file: tb/host_model.sv
`timescale 1ns/1ns
module host_model (
  // Clock
  input  wire logic       sys_clk,
  // Byte register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Bits the host may set; the rest go out as zero
  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    case (a)
      8'h07:   wr_mask = 8'h03;
      8'h0a:   wr_mask = 8'hf7;
      8'h0b:   wr_mask = 8'h1f;
      8'h0d:   wr_mask = 8'h03;
      default: wr_mask = 8'hff;
    endcase
  endfunction : wr_mask

  // Idle bus shows inverted values so a stale byte never looks current
  task automatic idle_bus();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle_bus

  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    // Undefined current and unusable margin codes are never sent
    if ((a == 8'h0a && d[7:5] > 3'h4) || (a == 8'h0d && d[1:0] == 2'h0)) begin
      return;
    end
    @(posedge sys_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d & wr_mask(a);
    reg_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    idle_bus();
  endtask : write_byte

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
    v = reg_rvalid;
    idle_bus();
  endtask : read_byte
endmodule : host_model

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;

  logic       sys_clk, rst_n, ce, reg_wr, reg_rd, reg_rvalid;
  logic       charge_state, active_state, standby_state, charge_start, energy_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [4:0] vcap_code_pin, chend_code, vcap_max_code, margin_target_code;
  logic [2:0] vmin_code, ich_code;
  logic [3:0] vew_code;
  logic [5:0] profile_index;
  logic [1:0] opt_margin;
  logic       vcap_max_high, ew_enable, high_side_hiz, fixed_mode, cfg_misuse;
  int         failures, n_compared, cycles;

  // Field views per register; only 0a and 0b are laid out like the written byte
  row_type rows [20] = '{
    '{8'h0a, 8'h00, 8'h00}, '{8'h0a, 8'h31, 8'h31},
    '{8'h0a, 8'h42, 8'h42}, '{8'h0a, 8'h73, 8'h73},
    '{8'h0a, 8'h84, 8'h84}, '{8'h0b, 8'h19, 8'h19},
    '{8'h0b, 8'h07, 8'h07}, '{8'h0b, 8'h14, 8'h14},
    '{8'h0b, 8'h00, 8'h00}, '{8'h0c, 8'h10, 8'h3f},
    '{8'h0c, 8'h00, 8'h1c}, '{8'h0d, 8'h01, 8'h4c},
    '{8'h0d, 8'h02, 8'h8e}, '{8'h0d, 8'h03, 8'hd0},
    '{8'h07, 8'h03, 8'h30}, '{8'h08, 8'hf0, 8'h3f},
    '{8'h07, 8'h00, 8'h0f}, '{8'h08, 8'h00, 8'h80},
    '{8'h08, 8'h10, 8'h01}, '{8'h0d, 8'h00, 8'hd0}
  };

  energy_manager_config_status_regs #(.CNT_W(32)) i_energy_manager_config_status_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .charge_state(charge_state), .active_state(active_state),
    .standby_state(standby_state), .charge_start(charge_start), .energy_tick(energy_tick),
    .vcap_code_pin(vcap_code_pin), .chend_code(chend_code), .vcap_max_high(vcap_max_high),
    .vcap_max_code(vcap_max_code), .vmin_code(vmin_code), .ich_code(ich_code),
    .vew_code(vew_code), .ew_enable(ew_enable), .high_side_hiz(high_side_hiz),
    .profile_index(profile_index), .fixed_mode(fixed_mode), .opt_margin(opt_margin),
    .margin_target_code(margin_target_code), .cfg_misuse(cfg_misuse));

  host_model i_host_model (
    .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] field_of(input logic [7:0] a);
    case (a)
      8'h0a:   field_of = {ich_code, high_side_hiz, 1'b0, vmin_code};
      8'h0b:   field_of = {3'h0, ew_enable, vew_code};
      8'h0c:   field_of = {2'h0, vcap_max_high, vcap_max_code};
      8'h0d:   field_of = {opt_margin, 1'b0, margin_target_code};
      default: field_of = {fixed_mode, 1'b0, profile_index};
    endcase
  endfunction : field_of

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host_model.read_byte(a, d, v);
    check({name, " valid"}, {7'h0, v}, 8'h01);
    check(name, d, exp);
  endtask : rd_chk

  task automatic ticks(input int n);
    repeat (n) begin
      energy_tick = 1'b1;
      cyc(1);
      energy_tick = 1'b0;
      cyc(1);
    end
  endtask : ticks

  task automatic check_reset();
    check("rst thr", field_of(8'h0a), 8'h40);
    check("rst warn", field_of(8'h0b), 8'h00);
    check("rst lim", field_of(8'h0c), 8'h1c);
    check("rst marg", field_of(8'h0d), 8'hd0);
    check("rst prof", field_of(8'h07), 8'h80);
    check("rst misuse", {7'h0, cfg_misuse}, 8'h00);
    for (int i = 1; i < 7; i++) rd_chk("rst rd", 8'(i), 8'h00);
    $display("test reset done");
  endtask : check_reset

  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Ceiling well above the roughly 740 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      results();
    end
  end

  initial begin
    {rst_n, charge_state, active_state, charge_start, energy_tick} = 5'h00;
    {ce, standby_state} = 2'h3;
    vcap_code_pin = 5'h00;
    chend_code    = 5'h00;
    cyc(12);
    rst_n = 1'b1;
    check_reset();
    foreach (rows[i]) begin
      i_host_model.write_byte(rows[i].a, rows[i].d);
      check("field", field_of(rows[i].a), rows[i].e);
    end
    $display("test fields done");
    rd_chk("wo read", 8'h0a, 8'h00);
    rd_chk("unmapped", 8'h0e, 8'h00);
    ce = 1'b0;
    i_host_model.write_byte(8'h0b, 8'h1f);
    ce = 1'b1;
    check("ce low", field_of(8'h0b), 8'h00);
    i_host_model.write_byte(8'h0a, 8'h50);
    standby_state = 1'b0;
    cyc(1);
    check("hiz idle", {7'h0, high_side_hiz}, 8'h00);
    active_state = 1'b1;
    cyc(1);
    check("hiz act", {7'h0, high_side_hiz}, 8'h01);
    active_state = 1'b0;
    standby_state = 1'b1;
    $display("test refuse and hiz done");
    ticks(300);
    for (int i = 1; i < 5; i++) rd_chk("energy", 8'(i), 8'(32'h12c >> (32 - 8 * i)));
    ticks(2);
    for (int i = 2; i < 5; i++) rd_chk("snap", 8'(i), 8'(32'h12c >> (32 - 8 * i)));
    rd_chk("live", 8'h01, 8'h00);
    rd_chk("snap2", 8'h04, 8'h2e);
    chend_code   = 5'h1a;
    charge_start = 1'b1;
    energy_tick  = 1'b1;
    cyc(1);
    {charge_start, energy_tick} = 2'h0;
    chend_code = 5'h05;
    for (int i = 1; i < 5; i++) rd_chk("cleared", 8'(i), 8'h00);
    rd_chk("target", 8'h06, 8'h1a);
    $display("test energy done");
    {charge_state, standby_state} = 2'h2;
    vcap_code_pin = 5'h1f;
    cyc(5);
    rd_chk("vcap chg", 8'h05, 8'h1f);
    {charge_state, standby_state} = 2'h1;
    vcap_code_pin = 5'h02;
    cyc(5);
    rd_chk("vcap stb", 8'h05, 8'h1f);
    {active_state, standby_state} = 2'h2;
    cyc(5);
    rd_chk("vcap act", 8'h05, 8'h02);
    {active_state, standby_state} = 2'h1;
    $display("test vcap done");
    check("misuse", {7'h0, cfg_misuse}, 8'h00);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    check_reset();
    results();
  end
endmodule : tb_top
